/* File: bench/lhc_control_regs_tb.sv */
// Self-checking testbench of the host control register bank.
`timescale 1ns/100ps
module lhc_control_regs_tb;
    import lhc_pkg::*;

    localparam logic [31:0] TB_ID   = 32'h0055_AA00; // Arbitrary identifier value.
    localparam logic [31:0] OWNER_B = 32'h1 << BIT_OWNER;
    localparam logic [31:0] LATE_B  = 32'h1 << BIT_LATE_ACK;
    localparam logic [31:0] LINK_B  = 32'h1 << BIT_LINK_ONLINE;
    localparam logic [31:0] SWAP_B  = 32'h1 << BIT_SWAP_BYPASS;

    logic          clk_i;
    logic          rst_n_i;
    logic          ce_i;
    lhc_reg_req_t  reg_req;
    logic          reg_ack_o;
    logic [31:0]   reg_rdata_o;
    lhc_pw_fail_t  pw_fail;
    logic          eeprom_load;
    logic          eeprom_owner;
    logic          fetch_error;
    logic          bus_reset;
    lhc_pkt_t      pkt;
    lhc_ack_t      ack_o;
    logic          rom_serve_o;
    logic          pkt_forward_o;
    logic          late_ack_event_o;
    logic          rom_regs_update_o;
    logic          image_ready_o;
    logic          swap_bypass_o;
    logic          late_ack_permit_o;
    logic          enhancements_on_o;
    logic          link_online_o;
    logic          soft_reset_o;
    int            failures;
    int            num_checks;

    lhc_control_regs #(.COMPANY_ID(TB_ID), .SOFT_RESET_CYCLES(2)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_req_i(reg_req), .reg_ack_o(reg_ack_o),
        .reg_rdata_o(reg_rdata_o), .pw_fail_i(pw_fail), .eeprom_load_i(eeprom_load),
        .eeprom_owner_i(eeprom_owner), .fetch_error_i(fetch_error), .bus_reset_i(bus_reset),
        .pkt_i(pkt), .ack_o(ack_o), .rom_serve_o(rom_serve_o), .pkt_forward_o(pkt_forward_o),
        .late_ack_event_o(late_ack_event_o), .rom_regs_update_o(rom_regs_update_o),
        .image_ready_o(image_ready_o), .swap_bypass_o(swap_bypass_o),
        .late_ack_permit_o(late_ack_permit_o), .enhancements_on_o(enhancements_on_o),
        .link_online_o(link_online_o), .soft_reset_o(soft_reset_o));

    lhc_remote_node node (.clk_i(clk_i), .pkt_o(pkt), .pw_fail_o(pw_fail), .bus_reset_o(bus_reset));

    // A 50 ns clock.
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Compares one value and reports a mismatch at once.
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One register access; the answer is looked at in the cycle after the request is taken.
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_req <= '{req: 1'b1, wr: wr, addr: a, wdata: d};
        @(posedge clk_i);
        reg_req.req <= 1'b0;
        #1;
        check_val("reg_ack_o", 32'h1, {31'h0, reg_ack_o});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_acc(1'b0, a, 32'h0);
        check_val("reg_rdata_o", exp, reg_rdata_o);
    endtask

    // Packs the acknowledge outputs as {valid, code, serve, forward, late event}.
    task automatic check_pkt(input logic [7:0] exp);
        check_val("ack", {24'h0, exp}, {24'h0, ack_o.valid, ack_o.valid ? ack_o.code : 4'h0,
                  rom_serve_o, pkt_forward_o, late_ack_event_o});
    endtask

    // Loads the owner bit from the EEPROM side for one cycle.
    task automatic load_owner(input logic v);
        @(posedge clk_i);
        eeprom_load <= 1'b1;
        eeprom_owner <= v;
        @(posedge clk_i);
        eeprom_load <= 1'b0;
    endtask

    task automatic end_sim();
        if (failures == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The tests take under a hundred cycles; a hang is cut short well after that.
    initial begin
        repeat (3000) @(posedge clk_i);
        failures++;
        end_sim();
    end

    // Main sequence.
    initial begin
        failures = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        reg_req = '0;
        eeprom_load = 1'b0;
        eeprom_owner = 1'b1;
        fetch_error = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(OFF_FLAGS_SET, OWNER_B);
        rd(OFF_COMPANY_ID, TB_ID);
        reg_acc(1'b1, OFF_COMPANY_ID, 32'hFFFF_FFFF);
        rd(OFF_COMPANY_ID, TB_ID);
        rd(8'h44, READ_ZERO);
        reg_acc(1'b1, OFF_FLAGS_SET, FLAGS_IMG_MASK);
        reg_acc(1'b1, OFF_FLAGS_SET, 32'hFFFE_FFFF);
        rd(OFF_FLAGS_CLR, FLAGS_IMG_MASK | FLAGS_RSC_MASK | OWNER_B);
        check_val("flag outputs", 32'h3E, {26'h0, image_ready_o, swap_bypass_o, late_ack_permit_o,
                  enhancements_on_o, link_online_o, soft_reset_o});
        reg_acc(1'b1, OFF_FLAGS_CLR, 32'h0000_0000);
        reg_acc(1'b1, OFF_FLAGS_CLR, FLAGS_IMG_MASK | 32'h1F80_FFFF);
        rd(OFF_FLAGS_SET, FLAGS_IMG_MASK | FLAGS_RSC_MASK | OWNER_B);
        reg_acc(1'b1, OFF_FLAGS_CLR, SWAP_B);
        check_val("swap_bypass_o", 32'h0, {31'h0, swap_bypass_o});
        reg_acc(1'b1, OFF_FLAGS_SET, SWAP_B);
        check_val("swap_bypass_o", 32'h1, {31'h0, swap_bypass_o});
        node.send_pkt(1'b1);
        check_pkt({1'b1, ACK_TARDY, 3'b001});
        node.send_pkt(1'b0);
        check_pkt({1'b1, ACK_TARDY, 3'b001});
        reg_acc(1'b1, OFF_FLAGS_CLR, LATE_B);
        node.send_pkt(1'b1);
        check_pkt({1'b1, ACK_PENDING, 3'b100});
        node.send_pkt(1'b0);
        check_pkt({1'b1, ACK_PENDING, 3'b010});
        node.pulse_bus_reset();
        check_val("rom_regs_update_o", 32'h1, {31'h0, rom_regs_update_o});
        @(posedge clk_i);
        fetch_error <= 1'b1;
        @(posedge clk_i);
        fetch_error <= 1'b0;
        #1;
        check_val("image_ready_o", 32'h0, {31'h0, image_ready_o});
        node.send_pkt(1'b1);
        check_pkt({1'b1, ACK_TYPE_ERROR, 3'b000});
        node.pulse_bus_reset();
        check_val("rom_regs_update_o", 32'h0, {31'h0, rom_regs_update_o});
        reg_acc(1'b1, OFF_FLAGS_SET, FLAGS_IMG_MASK);
        check_val("image_ready_o", 32'h0, {31'h0, image_ready_o});
        reg_acc(1'b1, OFF_FLAGS_CLR, LINK_B);
        node.send_pkt(1'b0);
        check_pkt(8'h00);
        rd(OFF_FLAGS_SET, (FLAGS_RSC_MASK & ~(LATE_B | LINK_B)) | OWNER_B);
        // A failed write leaves its origin; software writes do not touch it.
        node.report_fail('{failed_write_requester: '{bus: 10'h2AB, node: 6'h15},
                           failed_write_offset_upper: 16'hBEEF});
        rd(OFF_ORIGIN_HI, {10'h2AB, 6'h15, 16'hBEEF});
        reg_acc(1'b1, OFF_ORIGIN_HI, 32'h0);
        rd(OFF_ORIGIN_HI, {10'h2AB, 6'h15, 16'hBEEF});
        // The owner bit follows the EEPROM and ignores software.
        load_owner(1'b0);
        reg_acc(1'b1, OFF_FLAGS_SET, OWNER_B);
        // A clear write offered while the clock enable is low must never land.
        @(posedge clk_i);
        ce_i <= 1'b0;
        reg_req <= '{req: 1'b1, wr: 1'b1, addr: OFF_FLAGS_CLR, wdata: FLAGS_RSC_MASK};
        repeat (2) @(posedge clk_i);
        reg_req.req <= 1'b0;
        ce_i <= 1'b1;
        rd(OFF_FLAGS_SET, FLAGS_RSC_MASK & ~(LATE_B | LINK_B));
        // Software clear runs for two cycles, then everything but the owner bit is back at reset.
        reg_acc(1'b1, OFF_FLAGS_SET, LINK_B | FLAGS_SOFT_MASK);
        check_val("soft_reset_o", 32'h1, {31'h0, soft_reset_o});
        check_val("link_online_o", 32'h0, {31'h0, link_online_o});
        @(posedge clk_i);
        #1;
        check_val("soft_reset_o", 32'h1, {31'h0, soft_reset_o});
        @(posedge clk_i);
        #1;
        check_val("soft_reset_o", 32'h0, {31'h0, soft_reset_o});
        rd(OFF_FLAGS_SET, FLAGS_RESET);
        rd(OFF_ORIGIN_HI, ORIGIN_RESET);
        end_sim();
    end
endmodule // lhc_control_regs_tb

/* File: bench/lhc_remote_node.sv */
// Model of the serial bus side: remote requesters, the posted write engine and bus resets.
`timescale 1ns/100ps
module lhc_remote_node (
    input  wire logic           clk_i,        // Bench clock.
    output lhc_pkg::lhc_pkt_t    pkt_o,       // Packet addressed to this node.
    output lhc_pkg::lhc_pw_fail_t pw_fail_o,  // Posted write failure report.
    output logic                 bus_reset_o  // Serial bus reset.
);
    import lhc_pkg::*;

    // Nothing is offered until a task asks for it.
    initial begin
        pkt_o       = '0;
        pw_fail_o   = '0;
        bus_reset_o = 1'b0;
    end

    // A packet is offered for one cycle, then withdrawn; returns just after the answer edge.
    task automatic send_pkt(input logic rom);
        @(posedge clk_i);
        pkt_o <= '{valid: 1'b1, rom_block_read: rom};
        @(posedge clk_i);
        pkt_o <= '0;
        #1;
    endtask

    // A failed posted write is reported for one cycle with its origin.
    task automatic report_fail(input lhc_origin_t origin);
        @(posedge clk_i);
        pw_fail_o <= '{valid: 1'b1, origin: origin};
        @(posedge clk_i);
        pw_fail_o <= '0;
        #1;
    endtask

    // A serial bus reset is signalled for one cycle.
    task automatic pulse_bus_reset();
        @(posedge clk_i);
        bus_reset_o <= 1'b1;
        @(posedge clk_i);
        bus_reset_o <= 1'b0;
        #1;
    endtask
endmodule // lhc_remote_node

/* File: hdl/lhc_ack_sel.sv */
// Acknowledge selection for packets addressed to this node.
`timescale 1ns/100ps
module lhc_ack_sel (
    input  wire logic          link_online_i,   // Link is connected to the bus.
    input  wire logic          image_ready_i,   // Configuration ROM image is valid.
    input  wire logic          late_ack_i,      // Tardy acknowledge permitted.
    input  wire lhc_pkg::lhc_pkt_t pkt_i,       // Incoming packet.
    output lhc_pkg::lhc_ack_t  ack_o,           // Acknowledge to send.
    output logic               serve_o,         // ROM block read is to be served.
    output logic               forward_o,       // Packet goes on to normal handling.
    output logic               tardy_o          // A tardy acknowledge is sent.
);
    import lhc_pkg::*;

    // Offline packets get no answer at all; tardy takes precedence over everything else.
    always_comb begin
        ack_o     = '{valid: 1'b0, code: ACK_NONE};
        serve_o   = 1'b0;
        forward_o = 1'b0;
        tardy_o   = 1'b0;
        if (pkt_i.valid && link_online_i) begin
            ack_o.valid = 1'b1;
            if (late_ack_i) begin
                ack_o.code = ACK_TARDY;
                tardy_o    = 1'b1;
            end else if (pkt_i.rom_block_read && !image_ready_i) begin
                ack_o.code = ACK_TYPE_ERROR;
            end else if (pkt_i.rom_block_read) begin
                ack_o.code = ACK_PENDING;
                serve_o    = 1'b1;
            end else begin
                ack_o.code = ACK_PENDING;
                forward_o  = 1'b1;
            end
        end
    end

endmodule // lhc_ack_sel

/* File: hdl/lhc_control_regs.sv */
// Host control register bank: failed write origin, company identifier and host flags.
`timescale 1ns/100ps
module lhc_control_regs #(
    parameter logic [31:0] COMPANY_ID        = 32'h00A5_5A00, // Arbitrary neutral identifier.
    parameter int          SOFT_RESET_CYCLES = 16             // Length of a software initiated clear.
) (
    input  wire logic                 clk_i,              // 20 MHz clock.
    input  wire logic                 rst_n_i,            // Synchronous reset, active low.
    input  wire logic                 ce_i,               // Clock enable, freezes state when low.
    input  wire lhc_pkg::lhc_reg_req_t reg_req_i,         // Host register access.
    output logic                      reg_ack_o,          // Access done, one cycle pulse.
    output logic [31:0]               reg_rdata_o,        // Read data.
    input  wire lhc_pkg::lhc_pw_fail_t pw_fail_i,         // Posted write failure report.
    input  wire logic                 eeprom_load_i,      // EEPROM load strobe.
    input  wire logic                 eeprom_owner_i,     // Owner value from EEPROM.
    input  wire logic                 fetch_error_i,      // Bus info block fetch failed.
    input  wire logic                 bus_reset_i,        // Serial bus reset seen.
    input  wire lhc_pkg::lhc_pkt_t    pkt_i,              // Packet addressed to this node.
    output lhc_pkg::lhc_ack_t         ack_o,              // Acknowledge to send.
    output logic                      rom_serve_o,        // Serve a ROM block read.
    output logic                      pkt_forward_o,      // Hand packet on.
    output logic                      late_ack_event_o,   // Late acknowledge event pulse.
    output logic                      rom_regs_update_o,  // Update ROM shadow registers.
    output logic                      image_ready_o,      // Configuration image valid.
    output logic                      swap_bypass_o,      // Byte swap bypass for DMA.
    output logic                      late_ack_permit_o,  // Tardy acknowledge permitted.
    output logic                      enhancements_on_o,  // Bus enhancements enabled.
    output logic                      link_online_o,      // Link connected to bus.
    output logic                      soft_reset_o        // Software clear in progress.
);
    import lhc_pkg::*;

    localparam int CNT_W = $clog2(SOFT_RESET_CYCLES + 1);
    localparam logic [CNT_W-1:0] SOFT_LAST = CNT_W'(SOFT_RESET_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

    // Refuse reset lengths the counter and its checks cannot serve.
    if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 512) begin : g_bad_len
        $error("SOFT_RESET_CYCLES must lie between 1 and 512");
    end

    // Whole state of the bank.
    typedef struct packed {
        logic [31:0] flags;
        logic        owner;
        lhc_origin_t origin;
        logic [CNT_W-1:0] soft_cnt;
        logic        reg_ack;
        logic [31:0] rdata;
        lhc_ack_t    ack;
        logic        rom_serve;
        logic        forward;
        logic        tardy_evt;
        logic        rom_upd;
    } lhc_state_t;

    localparam lhc_state_t ST_RESET = '{
        flags:     FLAGS_RESET,
        owner:     OWNER_DEFAULT,
        origin:    ORIGIN_RESET,
        soft_cnt:  CNT_ZERO,
        reg_ack:   1'b0,
        rdata:     READ_ZERO,
        ack:       '{valid: 1'b0, code: ACK_NONE},
        rom_serve: 1'b0,
        forward:   1'b0,
        tardy_evt: 1'b0,
        rom_upd:   1'b0
    };

    lhc_state_t  st_r;
    lhc_state_t  st_nxt;
    logic        wr_set;
    logic        wr_clr;
    logic        rd_req;
    logic [31:0] flags_view;
    logic [31:0] set_bits;
    logic        soft_active;
    lhc_ack_t    sel_ack;
    logic        sel_serve;
    logic        sel_forward;
    logic        sel_tardy;

    // Decoded accesses.
    assign wr_set      = reg_req_i.req && reg_req_i.wr && (reg_req_i.addr == OFF_FLAGS_SET);
    assign wr_clr      = reg_req_i.req && reg_req_i.wr && (reg_req_i.addr == OFF_FLAGS_CLR);
    assign rd_req      = reg_req_i.req && !reg_req_i.wr;
    assign soft_active = st_r.flags[BIT_SOFT_CLEAR];

    // Acknowledge decision from the current flag values.
    lhc_ack_sel u_ack_sel (
        .link_online_i (st_r.flags[BIT_LINK_ONLINE]),
        .image_ready_i (st_r.flags[BIT_IMAGE_READY]),
        .late_ack_i    (st_r.flags[BIT_LATE_ACK]),
        .pkt_i         (pkt_i),
        .ack_o         (sel_ack),
        .serve_o       (sel_serve),
        .forward_o     (sel_forward),
        .tardy_o       (sel_tardy)
    );

    // Flag view seen by software; reserved bits are masked to zero and the owner bit is inserted.
    always_comb begin
        flags_view            = st_r.flags & FLAGS_STORED;
        flags_view[BIT_OWNER] = st_r.owner;
    end

    // Bits a write to the set address may raise; the image bit only while offline.
    always_comb begin
        set_bits = reg_req_i.wdata & (FLAGS_RSC_MASK | FLAGS_SOFT_MASK);
        if (!st_r.flags[BIT_LINK_ONLINE]) begin
            set_bits = set_bits | (reg_req_i.wdata & FLAGS_IMG_MASK);
        end
    end

    // Next state of the whole bank.
    always_comb begin
        st_nxt = st_r;

        // Read side: one cycle answer, unmapped offsets read zero, writes never touch read-only words.
        st_nxt.reg_ack = reg_req_i.req;
        st_nxt.rdata   = READ_ZERO;
        if (rd_req) begin
            case (reg_req_i.addr)
                OFF_ORIGIN_HI:  st_nxt.rdata = st_r.origin;
                OFF_COMPANY_ID: st_nxt.rdata = COMPANY_ID;
                OFF_FLAGS_SET:  st_nxt.rdata = flags_view;
                OFF_FLAGS_CLR:  st_nxt.rdata = flags_view;
                default:        st_nxt.rdata = READ_ZERO;
            endcase
        end

        // Packet side outputs are registered copies of the selector.
        st_nxt.ack       = sel_ack;
        st_nxt.rom_serve = sel_serve;
        st_nxt.forward   = sel_forward;
        st_nxt.tardy_evt = sel_tardy;
        st_nxt.rom_upd   = bus_reset_i && st_r.flags[BIT_IMAGE_READY];

        // EEPROM load of the owner bit survives a software clear.
        if (eeprom_load_i) begin
            st_nxt.owner = eeprom_owner_i;
        end

        if (soft_active) begin
            // Hold flags and origin cleared, keep the reset bit high until the count is done.
            st_nxt.origin = ORIGIN_RESET;
            if (st_r.soft_cnt == SOFT_LAST) begin
                st_nxt.flags    = FLAGS_RESET;
                st_nxt.soft_cnt = CNT_ZERO;
            end else begin
                st_nxt.flags    = FLAGS_SOFT_MASK;
                st_nxt.soft_cnt = st_r.soft_cnt + CNT_ONE;
            end
        end else begin
            // Failed posted write report.
            if (pw_fail_i.valid) begin
                st_nxt.origin.failed_write_requester    = pw_fail_i.origin.failed_write_requester;
                st_nxt.origin.failed_write_offset_upper = pw_fail_i.origin.failed_write_offset_upper;
            end
            // Set and clear writes; zero data bits leave flags alone unless a set write raises the reset bit.
            if (wr_set) begin
                st_nxt.flags = st_r.flags | set_bits;
                if (reg_req_i.wdata[BIT_SOFT_CLEAR]) begin
                    st_nxt.flags = FLAGS_SOFT_MASK;
                end
            end else if (wr_clr) begin
                st_nxt.flags = st_r.flags & ~(reg_req_i.wdata & FLAGS_RSC_MASK);
            end
            // A fetch error drops the image flag.
            if (fetch_error_i) begin
                st_nxt.flags[BIT_IMAGE_READY] = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= ST_RESET;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register.
    assign reg_ack_o         = st_r.reg_ack;
    assign reg_rdata_o       = st_r.rdata;
    assign ack_o             = st_r.ack;
    assign rom_serve_o       = st_r.rom_serve;
    assign pkt_forward_o     = st_r.forward;
    assign late_ack_event_o  = st_r.tardy_evt;
    assign rom_regs_update_o = st_r.rom_upd;
    assign image_ready_o     = st_r.flags[BIT_IMAGE_READY];
    assign swap_bypass_o     = st_r.flags[BIT_SWAP_BYPASS];
    assign late_ack_permit_o = st_r.flags[BIT_LATE_ACK];
    assign enhancements_on_o = st_r.flags[BIT_ENHANCE_ON];
    assign link_online_o     = st_r.flags[BIT_LINK_ONLINE];
    assign soft_reset_o      = st_r.flags[BIT_SOFT_CLEAR];

    // Checks on the bank behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Failure report lands in the origin register.
    a_origin_requester: assert property (
        ce_i && pw_fail_i.valid && !soft_active
        |=> st_r.origin.failed_write_requester == $past(pw_fail_i.origin.failed_write_requester))
        else $error("requester not captured");

    a_origin_offset: assert property (
        ce_i && pw_fail_i.valid && !soft_active
        |=> st_r.origin.failed_write_offset_upper == $past(pw_fail_i.origin.failed_write_offset_upper))
        else $error("upper offset not captured");

    // Software writes never alter the origin register.
    a_origin_readonly: assert property (
        ce_i && reg_req_i.req && reg_req_i.wr && !pw_fail_i.valid && !soft_active
        |=> $stable(st_r.origin))
        else $error("origin changed by write");

    // The identifier reads back fixed.
    a_company_read: assert property (
        ce_i && rd_req && reg_req_i.addr == OFF_COMPANY_ID
        |=> reg_ack_o && reg_rdata_o == COMPANY_ID)
        else $error("company identifier wrong");

    // Set and clear addresses move the swap bit.
    a_flags_setclr: assert property (
        ce_i && !soft_active && (wr_set || wr_clr) && reg_req_i.wdata[BIT_SWAP_BYPASS]
        && !reg_req_i.wdata[BIT_SOFT_CLEAR]
        |=> swap_bypass_o == $past(wr_set))
        else $error("set or clear address ineffective");

    // Zero bits of a clear write leave the late permit alone.
    a_clear_zero_bits: assert property (
        ce_i && !soft_active && !fetch_error_i && wr_clr && !reg_req_i.wdata[BIT_LATE_ACK]
        |=> $stable(late_ack_permit_o))
        else $error("unwritten flag changed");

    // Image not ready gives type error on ROM block reads.
    a_rom_type_error: assert property (
        ce_i && pkt_i.valid && pkt_i.rom_block_read && link_online_o && !image_ready_o && !late_ack_permit_o
        |=> ack_o.valid && ack_o.code == ACK_TYPE_ERROR && !rom_serve_o)
        else $error("missing type error");

    // No shadow update without a valid image.
    a_rom_no_update: assert property (
        ce_i && bus_reset_i && !image_ready_o |=> !rom_regs_update_o)
        else $error("ROM registers updated without image");

    // Fetch error clears the image flag.
    a_fetch_clears: assert property (
        ce_i && fetch_error_i |=> !image_ready_o)
        else $error("image flag survived fetch error");

    // A packet met with the tardy permit is answered tardy and raises the late event.
    a_tardy_event: assert property (
        ce_i && pkt_i.valid && link_online_o && late_ack_permit_o
        |=> ack_o.valid && ack_o.code == ACK_TARDY && late_ack_event_o)
        else $error("late event and tardy ack disagree");

    // Reserved bits and owner bit on flag reads.
    a_flag_reserved: assert property (
        ce_i && rd_req && reg_req_i.addr == OFF_FLAGS_SET
        |=> reg_rdata_o[28:24] == 5'h00 && reg_rdata_o[BIT_OWNER] == $past(st_r.owner))
        else $error("reserved flag bits not zero");

    // Offline link answers nothing.
    a_offline_silent: assert property (
        ce_i && !link_online_o |=> !ack_o.valid)
        else $error("acknowledge while offline");

    // Software clear reads one then ends within the bound.
    a_soft_clear_ends: assert property (
        ce_i && !soft_active && wr_set && reg_req_i.wdata[BIT_SOFT_CLEAR]
        |=> soft_reset_o && !link_online_o ##[1:1000] !soft_reset_o)
        else $error("software clear did not complete");

    c_rom_served:   cover property (ce_i && pkt_i.valid && pkt_i.rom_block_read ##1 rom_serve_o);
    c_tardy_sent:   cover property (late_ack_event_o);
    c_origin_taken: cover property (ce_i && pw_fail_i.valid ##1 ce_i && rd_req && reg_req_i.addr == OFF_ORIGIN_HI);
    c_soft_clear:   cover property (soft_reset_o ##1 !soft_reset_o);

endmodule // lhc_control_regs

/* File: hdl/lhc_pkg.sv */
// Constants, field layouts and carrier types of the link host control register bank.
// Function
// - Failed write stores requester bus and node.
// - Failed write stores upper destination offset.
// - Origin register is read-only, hardware updated.
// - Company identifier is fixed, writes ignored.
// - Flags set at 50h, cleared at 54h.
// - Image ready enables configuration ROM responses.
// - Image not ready answers ROM reads type_error; the bank answers tardy instead while the late permit is set.
// - No ROM register update without image ready.
// - Image ready cleared by resets, fetch error.
// - Bit 30 selects DMA byte swap bypass.
// - Late acknowledge permit answers packets tardy.
// - Every tardy acknowledge raises a late event.
// - Bits 28 to 24 read zero.
// - Owner bit read-only, EEPROM loaded, default one.
// - Link offline blocks all packet traffic.
// - Software clear resets state, reads one meanwhile.
package lhc_pkg;

    // Register port geometry.
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;

    // Register byte offsets.
    localparam logic [7:0]  OFF_ORIGIN_HI   = 8'h3C;
    localparam logic [7:0]  OFF_COMPANY_ID  = 8'h40;
    localparam logic [7:0]  OFF_FLAGS_SET   = 8'h50;
    localparam logic [7:0]  OFF_FLAGS_CLR   = 8'h54;

    // Host flag bit positions.
    localparam int          BIT_IMAGE_READY = 31;
    localparam int          BIT_SWAP_BYPASS = 30;
    localparam int          BIT_LATE_ACK    = 29;
    localparam int          BIT_OWNER       = 23;
    localparam int          BIT_ENHANCE_ON  = 22;
    localparam int          BIT_LINK_POWER  = 19;
    localparam int          BIT_POSTED_WR   = 18;
    localparam int          BIT_LINK_ONLINE = 17;
    localparam int          BIT_SOFT_CLEAR  = 16;

    // Host flag masks: read/set/clear bits, the set-only image bit and the self-clearing reset bit.
    localparam logic [31:0] FLAGS_RSC_MASK  = 32'h604E_0000;
    localparam logic [31:0] FLAGS_IMG_MASK  = 32'h8000_0000;
    localparam logic [31:0] FLAGS_SOFT_MASK = 32'h0001_0000;
    localparam logic [31:0] FLAGS_STORED    = 32'hE04F_0000;
    localparam logic [31:0] FLAGS_RESET     = 32'h0000_0000;
    localparam logic [31:0] ORIGIN_RESET    = 32'h0000_0000;
    localparam logic        OWNER_DEFAULT   = 1'b1;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

    // Acknowledge codes of the serial bus.
    localparam logic [3:0]  ACK_NONE        = 4'h0;
    localparam logic [3:0]  ACK_PENDING     = 4'h2;
    localparam logic [3:0]  ACK_TARDY       = 4'hB;
    localparam logic [3:0]  ACK_TYPE_ERROR  = 4'hE;

    // One host register access.
    typedef struct packed {
        logic              req;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lhc_reg_req_t;

    // Requester of a failed posted write.
    typedef struct packed {
        logic [9:0] bus;
        logic [5:0] node;
    } lhc_requester_t;

    // Layout of the failed write origin register.
    typedef struct packed {
        lhc_requester_t failed_write_requester;
        logic [15:0]    failed_write_offset_upper;
    } lhc_origin_t;

    // Failure report from the posted write engine.
    typedef struct packed {
        logic        valid;
        lhc_origin_t origin;
    } lhc_pw_fail_t;

    // Incoming asynchronous packet addressed to this node.
    typedef struct packed {
        logic valid;
        logic rom_block_read;
    } lhc_pkt_t;

    // Acknowledge to send back on the bus.
    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } lhc_ack_t;

endpackage
